// ===== shared/lsd_pkg.sv
package lsd_pkg;
    // channel and frame sizes
    localparam int NUM_CH        = 8;
    localparam int FAULT_W       = 16;
    localparam int OC_MSB        = 15;           // overcurrent flags sit in the upper byte
    localparam int OC_LSB        = 8;
    localparam int OL_MSB        = 7;            // open-load flags sit in the lower byte
    localparam int OL_LSB        = 0;
    // reset values
    localparam logic [7:0]  CTRL_RESET  = 8'h00;
    localparam logic [15:0] FAULT_RESET = 16'h0000;
    // timing, pclk at 250 MHz
    localparam int CLK_MHZ       = 250;
    localparam int OC_DEG_NS     = 3500;         // overcurrent deglitch, typical
    localparam int OL_DEG_MIN_NS = 7000;         // open-load deglitch window
    localparam int OL_DEG_MAX_NS = 17000;
    localparam int OC_DEG_CYC    = (OC_DEG_NS * CLK_MHZ + 999) / 1000;
    localparam int OL_DEG_CYC    = (OL_DEG_MIN_NS * CLK_MHZ + 999) / 1000;
    localparam int OL_DEG_MAX_CYC = (OL_DEG_MAX_NS * CLK_MHZ) / 1000;
    // host side: link clock divider and apb register map
    localparam int SCLK_HALF_CYC = 8;            // 16 pclk per sclk, 64 ns
    localparam logic [7:0] ADDR_CTRL   = 8'h00;  // command: bit0 write, bit1 read
    localparam logic [7:0] ADDR_WDATA  = 8'h04;  // chain of channel bytes
    localparam logic [7:0] ADDR_RDATA  = 8'h08;  // received fault words
    localparam logic [7:0] ADDR_STATUS = 8'h0c;  // bit0 busy
    localparam logic [7:0] ADDR_IRQ    = 8'h10;  // sticky, write one to clear
    localparam logic [7:0] ADDR_MASK   = 8'h14;
    localparam int IRQ_DONE      = 0;            // frame finished
    localparam int IRQ_FAULT     = 1;            // alarm line seen low
endpackage : lsd_pkg

// ===== shared/lsd_link_if.sv
`timescale 1ns/100ps
interface lsd_link_if;
    logic sclk;           // serial clock from host
    logic sdi;            // host data into device
    logic latch;          // low write, high read
    logic enable;         // device enable, driven by host
    logic sdo_o;          // device data out
    logic sdo_oe_n;       // low while device drives sdo
    logic fault_alarm_o;  // open-drain pulldown value (always 0)
    logic fault_alarm_oe_n; // low while pulled down
    // resolved wire levels: released sdo floats, read as 1 via pull-up; alarm pulled up
    wire sdo_line          = sdo_oe_n ? 1'b1 : sdo_o;
    wire fault_alarm_n     = fault_alarm_oe_n ? 1'b1 : fault_alarm_o;
    modport device (input sclk, sdi, latch, enable, output sdo_o, sdo_oe_n, fault_alarm_o, fault_alarm_oe_n);
    modport host (output sclk, sdi, latch, enable, input sdo_line, fault_alarm_n);
endinterface : lsd_link_if

// ===== rtl/lsd_device.sv
`timescale 1ns/100ps
// How it works
// - enable low: clear all, outputs off, sdo released
// - enable high: channels follow bits, serial works
// - enable defaults low when undriven
// - write: sclk rise shifts sdi, sdo gets last
// - channel bit one on, zero off
// - read: fault word shifts out on sclk fall
// - upper byte overcurrent, lower byte open-load
// - sdo feeds next device sdi in chain
// - off channel, low sense sets open-load
// - open-load never blocks switching on
// - any open-load pulls alarm low
// - persistent overcurrent sets flag, latches off
// - any overcurrent pulls alarm low
// - writing zero clears latched overcurrent
// - alarm is open-drain, low on fault
// - over-temperature turns all channels off
// - overcurrent deglitch 3.5 us
// - open-load deglitch between 7 and 17 us
module lsd_device
    import lsd_pkg::*;
#(
    parameter int OC_DEG  = OC_DEG_CYC,
    parameter int OL_DEG  = OL_DEG_CYC
)(
    // clock and reset
    input  wire logic              pclk,
    input  wire logic              presetn,
    // link
    lsd_link_if.device             link,
    // analog sense inputs, asynchronous
    input  wire logic [NUM_CH-1:0] overcurrent_sense,  // current above threshold
    input  wire logic [NUM_CH-1:0] open_sense_low,     // off-state output below threshold
    input  wire logic              over_temp,          // with hysteresis outside
    // channel drive
    output logic [NUM_CH-1:0]      channel_output
);
    // three-stage synchronisers for every outside input
    localparam int NSYNC = 4 + 2*NUM_CH + 1;
    logic [NSYNC-1:0] s1_reg, s2_reg, s3_reg, filt_reg;
    wire  [NSYNC-1:0] raw = {link.sclk, link.sdi, link.latch, link.enable,
                             overcurrent_sense, open_sense_low, over_temp};

    // change counts once second and third stages agree
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s1_reg   <= '0;
            s2_reg   <= '0;
            s3_reg   <= '0;
            filt_reg <= '0;  // enable filtered low, device held in reset
        end
        else
        begin
            s1_reg <= raw;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            for (int i = 0; i < NSYNC; i++)
                if (s2_reg[i] == s3_reg[i])
                    filt_reg[i] <= s3_reg[i];
        end
    end

    // filtered views
    wire              sclk_f  = filt_reg[NSYNC-1];
    wire              sdi_f   = filt_reg[NSYNC-2];
    wire              latch_f = filt_reg[NSYNC-3];
    wire              en_f    = filt_reg[NSYNC-4];
    wire [NUM_CH-1:0] oc_f    = filt_reg[2*NUM_CH:NUM_CH+1];
    wire [NUM_CH-1:0] ol_f    = filt_reg[NUM_CH:1];
    wire              ot_f    = filt_reg[0];

    // edge detection on filtered link signals
    logic sclk_d_reg, latch_d_reg;
    wire  sclk_rise  = sclk_f & ~sclk_d_reg;
    wire  sclk_fall  = ~sclk_f & sclk_d_reg;
    wire  latch_rise = latch_f & ~latch_d_reg;

    // state
    logic [NUM_CH-1:0]  shift_reg;                 // write shift register
    logic [NUM_CH-1:0]  ctrl_reg;                  // channel_output_control
    logic [FAULT_W-1:0] fault_reg;                 // fault_indicator_word, read shifter
    logic [NUM_CH-1:0]  oc_flag_reg, ol_flag_reg;  // fault flags, overcurrent latched
    logic               sdo_reg, sdo_oe_n_reg, alarm_oe_n_reg;
    logic [NUM_CH-1:0]  out_reg;

    // per-channel deglitch counters and flags
    genvar g;
    generate
        for (g = 0; g < NUM_CH; g++)
        begin : g_ch
            logic [$clog2(OC_DEG+1)-1:0] oc_cnt_reg;
            logic [$clog2(OL_DEG+1)-1:0] ol_cnt_reg;
            wire on_now = out_reg[g];
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                begin
                    oc_cnt_reg     <= '0;
                    ol_cnt_reg     <= '0;
                    oc_flag_reg[g] <= 1'b0;
                    ol_flag_reg[g] <= 1'b0;
                end
                else if (!en_f)
                begin
                    // held in reset while disabled
                    oc_cnt_reg     <= '0;
                    ol_cnt_reg     <= '0;
                    oc_flag_reg[g] <= 1'b0;
                    ol_flag_reg[g] <= 1'b0;
                end
                else
                begin
                    // overcurrent: count only while on
                    if (on_now && oc_f[g])
                    begin
                        if (oc_cnt_reg == OC_DEG[$clog2(OC_DEG+1)-1:0])
                            oc_flag_reg[g] <= 1'b1;  // latch off
                        else
                            oc_cnt_reg <= oc_cnt_reg + 1'b1;
                    end
                    else
                        oc_cnt_reg <= '0;
                    // cleared only by a zero control bit; a new fault wins
                    if (!ctrl_reg[g] && !(on_now && oc_f[g]))
                        oc_flag_reg[g] <= 1'b0;
                    // open-load: off channels only, deglitched
                    if (!on_now && ol_f[g])
                    begin
                        if (ol_cnt_reg == OL_DEG[$clog2(OL_DEG+1)-1:0])
                            ol_flag_reg[g] <= 1'b1;
                        else
                            ol_cnt_reg <= ol_cnt_reg + 1'b1;
                    end
                    else
                    begin
                        ol_cnt_reg     <= '0;
                        ol_flag_reg[g] <= 1'b0;  // condition gone
                    end
                end
            end
        end
    endgenerate

    // channel drive: bit set, no latched overcurrent, not hot
    wire [NUM_CH-1:0] out_next = (en_f && !ot_f) ? (ctrl_reg & ~oc_flag_reg) : '0;
    wire              any_fault = (|oc_flag_reg) | (|ol_flag_reg);

    // serial interface and outputs
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sclk_d_reg     <= 1'b0;
            latch_d_reg    <= 1'b0;
            shift_reg      <= CTRL_RESET;
            ctrl_reg       <= CTRL_RESET;
            fault_reg      <= FAULT_RESET;
            sdo_reg        <= 1'b0;
            sdo_oe_n_reg   <= 1'b1;
            alarm_oe_n_reg <= 1'b1;
            out_reg        <= '0;
        end
        else
        begin
            sclk_d_reg     <= sclk_f;
            latch_d_reg    <= latch_f;
            out_reg        <= out_next;
            alarm_oe_n_reg <= ~any_fault;                      // open-drain pull
            if (!en_f)
            begin
                // register map cleared, sdo released
                shift_reg    <= CTRL_RESET;
                ctrl_reg     <= CTRL_RESET;
                fault_reg    <= FAULT_RESET;
                sdo_reg      <= 1'b0;
                sdo_oe_n_reg <= 1'b1;
            end
            else
            begin
                sdo_oe_n_reg <= 1'b0;
                if (latch_rise)
                begin
                    // load channels and snapshot faults
                    ctrl_reg  <= shift_reg;
                    fault_reg <= {oc_flag_reg, ol_flag_reg};
                    sdo_reg   <= oc_flag_reg[NUM_CH-1];
                end
                else if (!latch_f && sclk_rise)
                begin
                    // shift in, msb out for chain
                    shift_reg <= {shift_reg[NUM_CH-2:0], sdi_f};
                    sdo_reg   <= shift_reg[NUM_CH-1];
                end
                else if (latch_f && sclk_fall)
                begin
                    // fault word out, next device's word follows
                    fault_reg <= {fault_reg[FAULT_W-2:0], sdi_f};
                    sdo_reg   <= fault_reg[FAULT_W-2];
                end
            end
        end
    end

    // port drive
    assign link.sdo_o            = sdo_reg;
    assign link.sdo_oe_n         = sdo_oe_n_reg;
    assign link.fault_alarm_o    = 1'b0;
    assign link.fault_alarm_oe_n = alarm_oe_n_reg;
    assign channel_output        = out_reg;
endmodule : lsd_device

// ===== rtl/lsd_host.sv
// Added by the designer: the APB register port and the placing of the registers.
`timescale 1ns/100ps
// apb-controlled serial master; makes sclk by divider
module lsd_host
    import lsd_pkg::*;
#(
    parameter int N_DEV = 2    // devices in the chain
)(
    // apb slave
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             irq,
    // link
    lsd_link_if.host         link
);
    localparam int WW = 8*N_DEV;
    localparam int RW = 16*N_DEV;
    localparam int RN = 2*RW + 2;  // half periods in a frame, plus margin

    typedef enum logic [2:0] {ST_IDLE = 3'b001, ST_SHIFT = 3'b010, ST_LATCH = 3'b100} st_e;
    st_e st_reg;

    logic [WW-1:0] wdata_reg, wsh_reg;
    logic [RW-1:0] rdata_reg;
    logic          rd_mode_reg, en_reg, sclk_reg, sdi_reg, latch_reg;
    logic [7:0]    div_reg;
    logic [$clog2(RN+1)-1:0] half_reg;
    logic [1:0]    irq_st_reg, irq_mask_reg;
    logic [31:0]   prdata_reg;
    logic          pready_reg, irq_reg;
    logic          a1_reg, a2_reg, a3_reg, alarm_f_reg;  // alarm synchroniser
    logic          d1_reg, d2_reg, d3_reg, sdo_f_reg;    // sdo synchroniser

    // decoding
    wire access = psel & penable & pready_reg;
    wire wr     = access & pwrite;
    wire tick   = (div_reg == 8'(SCLK_HALF_CYC - 1));
    wire busy   = (st_reg != ST_IDLE);
    wire [31:0] rmux =
        (paddr == ADDR_WDATA)  ? 32'(wdata_reg) :
        (paddr == ADDR_RDATA)  ? 32'(rdata_reg) :
        (paddr == ADDR_STATUS) ? {31'h0, busy} :
        (paddr == ADDR_IRQ)    ? {30'h0, irq_st_reg} :
        (paddr == ADDR_MASK)   ? {30'h0, irq_mask_reg} :
        (paddr == ADDR_CTRL)   ? {31'h0, en_reg} : 32'h0;
    wire bad = !(paddr inside {ADDR_CTRL, ADDR_WDATA, ADDR_RDATA, ADDR_STATUS, ADDR_IRQ, ADDR_MASK});
    wire last = rd_mode_reg ? (half_reg == ($clog2(RN+1))'(2*RW)) : (half_reg == ($clog2(RN+1))'(2*WW));
    wire done_ev = (st_reg == ST_LATCH) & tick;

    // apb: one wait state, then answer
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_reg <= 1'b0;
            prdata_reg <= 32'h0;
        end
        else
        begin
            pready_reg <= psel & penable & ~pready_reg;
            prdata_reg <= (psel & penable & ~pready_reg & ~pwrite) ? rmux : 32'h0;
        end
    end

    // synchronisers for incoming pins
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            {a1_reg, a2_reg, a3_reg, alarm_f_reg, d1_reg, d2_reg, d3_reg, sdo_f_reg} <= 8'hff;
        else
        begin
            {a1_reg, a2_reg, a3_reg} <= {link.fault_alarm_n, a1_reg, a2_reg};
            {d1_reg, d2_reg, d3_reg} <= {link.sdo_line, d1_reg, d2_reg};
            if (a2_reg == a3_reg)
                alarm_f_reg <= a3_reg;
            if (d2_reg == d3_reg)
                sdo_f_reg <= d3_reg;
        end
    end

    // frame engine: sdi set on fall, taken on rise; read sampled before each fall
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st_reg       <= ST_IDLE;
            div_reg      <= 8'h00;
            half_reg     <= '0;
            wdata_reg    <= '0;
            wsh_reg      <= '0;
            rdata_reg    <= '0;
            rd_mode_reg  <= 1'b0;
            en_reg       <= 1'b0;
            sclk_reg     <= 1'b0;
            sdi_reg      <= 1'b0;
            latch_reg    <= 1'b0;
            irq_st_reg   <= 2'b00;
            irq_mask_reg <= 2'b00;
            irq_reg      <= 1'b0;
        end
        else
        begin
            div_reg <= (tick || !busy) ? 8'h00 : div_reg + 8'h01;
            irq_reg <= |(irq_st_reg & irq_mask_reg);
            // sticky events, set wins over clear
            irq_st_reg <= (irq_st_reg & ~((wr && paddr == ADDR_IRQ) ? pwdata[1:0] : 2'b00))
                          | {~alarm_f_reg, done_ev};
            if (wr && paddr == ADDR_MASK)
                irq_mask_reg <= pwdata[1:0];
            if (wr && paddr == ADDR_WDATA && !busy)
                wdata_reg <= pwdata[WW-1:0];
            case (st_reg)
                ST_IDLE:
                begin
                    if (wr && paddr == ADDR_CTRL)
                    begin
                        en_reg <= pwdata[2];
                        if (pwdata[0] || pwdata[1])
                        begin
                            rd_mode_reg <= pwdata[1];
                            latch_reg   <= pwdata[1];  // high selects read
                            // first bit set up a half period before the first rise
                            sdi_reg     <= pwdata[1] ? 1'b0 : wdata_reg[WW-1];
                            wsh_reg     <= {wdata_reg[WW-2:0], 1'b0};
                            half_reg    <= '0;
                            st_reg      <= ST_SHIFT;
                        end
                    end
                end
                ST_SHIFT:
                begin
                    if (tick)
                    begin
                        half_reg <= half_reg + 1'b1;
                        if (last)
                        begin
                            sclk_reg  <= 1'b0;
                            latch_reg <= ~rd_mode_reg;  // write frame ends with latch rise
                            st_reg    <= ST_LATCH;
                        end
                        else if (!sclk_reg)
                            sclk_reg <= 1'b1;  // sdi has stood still for a half period
                        else
                        begin
                            // next bit moves on the fall, never together with the rise
                            if (rd_mode_reg)
                                rdata_reg <= {rdata_reg[RW-2:0], sdo_f_reg};
                            else
                            begin
                                sdi_reg <= wsh_reg[WW-1];
                                wsh_reg <= {wsh_reg[WW-2:0], 1'b0};
                            end
                            sclk_reg <= 1'b0;
                        end
                    end
                end
                ST_LATCH:
                begin
                    if (tick)
                    begin
                        latch_reg <= 1'b0;
                        st_reg    <= ST_IDLE;
                    end
                end
                default: st_reg <= ST_IDLE;
            endcase
        end
    end

    assign prdata      = prdata_reg;
    assign pready      = pready_reg;
    assign pslverr     = 1'b0;
    assign irq         = irq_reg;
    assign link.sclk   = sclk_reg;
    assign link.sdi    = sdi_reg;
    assign link.latch  = latch_reg;
    assign link.enable = en_reg;
    wire unused_bad = bad;
endmodule : lsd_host

// ===== dv/lsd_monitor.sv
`timescale 1ns/100ps
// watches the link between host and device; all figures in pclk cycles
module lsd_monitor
    import lsd_pkg::*;
#(
    parameter int OC_DEG = OC_DEG_CYC,  // overcurrent deglitch count
    parameter int OL_DEG = OL_DEG_CYC   // open-load deglitch count
)(
    // clock and reset
    input wire logic              pclk,
    input wire logic              presetn,
    // link wires
    input wire logic              sclk,
    input wire logic              latch,
    input wire logic              enable,
    input wire logic              sdo_o,
    input wire logic              sdo_oe_n,
    input wire logic              fault_alarm_o,
    input wire logic              fault_alarm_oe_n,
    // channel side of the device
    input wire logic [NUM_CH-1:0] channel_output,
    input wire logic [NUM_CH-1:0] overcurrent_sense,
    input wire logic [NUM_CH-1:0] open_sense_low,
    input wire logic              over_temp
);
    default clocking dcb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    int  oc_cnt;  // run of cycles with an on channel over current
    int  ol_cnt;  // run of cycles with an off channel reading low
    wire oc_hit = |(overcurrent_sense & channel_output);
    wire ol_hit = enable && |(open_sense_low & ~channel_output);

    // run counters; margin of 10 covers the pin synchronisers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            oc_cnt <= 0;
            ol_cnt <= 0;
        end
        else
        begin
            oc_cnt <= oc_hit ? oc_cnt + 1 : 0;
            ol_cnt <= ol_hit ? ol_cnt + 1 : 0;
        end
    end

    a_reset_clears_outputs: assert property (!enable [*8] |-> sdo_oe_n && channel_output == 8'h00)
        else $error("outputs not cleared while enable low");
    a_alarm_open_drain: assert property (fault_alarm_o == 1'b0)
        else $error("alarm drives a high level");
    a_alarm_released_off: assert property (!enable [*8] |-> fault_alarm_oe_n)
        else $error("alarm held low while disabled");
    a_temp_all_off: assert property (over_temp [*8] |-> channel_output == 8'h00)
        else $error("channel on while hot");
    a_oc_latch_off: assert property (oc_cnt <= OC_DEG + 10)
        else $error("overcurrent channel not latched off");
    // a channel dropping while still over current must have waited the deglitch
    a_oc_deglitch_wait: assert property ((oc_cnt != 0 && !oc_hit && overcurrent_sense != 8'h00 && enable && !over_temp)
        |-> oc_cnt >= OC_DEG) else $error("overcurrent declared early");
    a_ol_alarm_low: assert property (ol_cnt >= OL_DEG + 10 |-> !fault_alarm_oe_n)
        else $error("open load not reported");
    a_sdo_write_rise: assert property (($changed(sdo_o) && !latch && !$past(latch, 6) && !sdo_oe_n
        && !$past(sdo_oe_n)) |-> sclk) else $error("write data moved outside clock high");
    a_sdo_read_fall: assert property (($changed(sdo_o) && latch && $past(latch, 6) && !sdo_oe_n
        && !$past(sdo_oe_n)) |-> !sclk) else $error("read data moved outside clock low");
endmodule : lsd_monitor

// ===== dv/tb.sv
`timescale 1ns/100ps
module tb;
    import lsd_pkg::*;
    localparam int OC_T = 20;  // shortened deglitch counts keep the run brief
    localparam int OL_T = 40;
    // clock, reset and apb
    logic              pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
    logic [7:0]        paddr;
    logic [31:0]       pwdata, prdata, rd_val;
    // analog stand-ins and channel drive
    logic [NUM_CH-1:0] overcurrent_sense, open_sense_low, channel_output;
    logic              over_temp;
    // bookkeeping: notes hold mask in the upper word, value below
    int                num_errors, num_checks, seed;
    logic [63:0]       exp_q[$];
    logic [7:0]        byte_v;

    lsd_link_if link ();
    lsd_host #(.N_DEV(1)) u_lsd_host (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .irq(irq), .link(link));
    lsd_device #(.OC_DEG(OC_T), .OL_DEG(OL_T)) u_lsd_device (.pclk(pclk), .presetn(presetn), .link(link),
        .overcurrent_sense(overcurrent_sense), .open_sense_low(open_sense_low), .over_temp(over_temp),
        .channel_output(channel_output));
    lsd_monitor #(.OC_DEG(OC_T), .OL_DEG(OL_T)) u_lsd_monitor (.pclk(pclk), .presetn(presetn),
        .sclk(link.sclk), .latch(link.latch), .enable(link.enable), .sdo_o(link.sdo_o),
        .sdo_oe_n(link.sdo_oe_n), .fault_alarm_o(link.fault_alarm_o), .fault_alarm_oe_n(link.fault_alarm_oe_n),
        .channel_output(channel_output), .overcurrent_sense(overcurrent_sense),
        .open_sense_low(open_sense_low), .over_temp(over_temp));

    // 250 MHz clock
    initial
    begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end

    task check(input logic [31:0] seen, input logic [31:0] want);
        num_checks++;
        if (seen !== want)
        begin
            num_errors++;
            $display("[ERR] %0t seen %h want %h", $time, seen, want);
        end
    endtask : check

    task finish_test();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : finish_test

    // one apb transfer; reads leave a note for the watcher
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] want,
             input logic [31:0] mask);
        if (!w)
            exp_q.push_back({mask, want});
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // hold the request until pready is seen at an edge; only the watchdog ends a hang
        do
        begin
            @(posedge pclk);
        end
        while (pready !== 1'b1);
        rd_val = prdata;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 32'h0, 32'h0);
    endtask : wr

    task rd(input logic [7:0] a, input logic [31:0] want, input logic [31:0] mask);
        apb(1'b0, a, 32'h0, want, mask);
    endtask : rd

    // start a frame and poll busy, bounded
    task frame(input logic [31:0] cmd);
        int n;
        wr(ADDR_CTRL, cmd);
        n = 0;
        do
        begin
            rd(ADDR_STATUS, 32'h0, 32'h0);
            n++;
        end
        while (rd_val[0] !== 1'b0 && n < 200);
        if (rd_val[0] !== 1'b0)
        begin
            num_errors++;
            finish_test();
        end
    endtask : frame

    // write frame with enable kept high; margin lets the pins settle
    task send(input logic [7:0] b);
        wr(ADDR_WDATA, {24'h0, b});
        frame(32'h5);
        repeat (8) @(posedge pclk);
    endtask : send

    // watcher: pops the oldest note for each read answer and compares it when its mask is nonzero
    always @(posedge pclk)
    begin
        logic [63:0] e;
        if (psel && penable && pready === 1'b1 && !pwrite)
        begin
            e = exp_q.pop_front();
            if (e[63:32] != 32'h0)
                check(prdata & e[63:32], e[31:0]);
        end
    end

    // watchdog well past the expected few thousand cycles
    initial
    begin
        #200000;
        num_errors++;
        finish_test();
    end

    initial
    begin
        seed = 99;
        presetn = 1'b0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {overcurrent_sense, open_sense_low, over_temp} = '0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
        check(channel_output, 32'h0);
        check(link.sdo_oe_n, 32'h1);
        check(link.fault_alarm_n, 32'h1);
        rd(ADDR_MASK, 32'h0, 32'hffffffff);
        rd(ADDR_IRQ, 32'h0, 32'hffffffff);
        rd(8'h18, 32'h0, 32'hffffffff);        // unmapped place reads zero
        $display("reset test done");
        // all-on, all-off, then random channel bytes; mask toggled so irq is seen both ways
        for (int i = 0; i < 6; i++)
        begin
            byte_v = (i == 0) ? 8'hff : (i == 1) ? 8'h00 : 8'($random(seed));
            wr(ADDR_MASK, 32'(i % 2));
            send(byte_v);
            check(channel_output, {24'h0, byte_v});
            rd(ADDR_IRQ, 32'h1, 32'h1);
            check(irq, 32'(i % 2));
            wr(ADDR_IRQ, 32'h1);
            repeat (3) @(posedge pclk);
            check(irq, 32'h0);
        end
        $display("write test done");
        // open load on two off channels
        send(8'h00);
        open_sense_low <= 8'h05;
        repeat (OL_T - 10) @(posedge pclk);
        check(link.fault_alarm_n, 32'h1);
        repeat (30) @(posedge pclk);
        check(link.fault_alarm_n, 32'h0);
        send(8'h00);
        frame(32'h6);
        rd(ADDR_RDATA, 32'h0005, 32'hffff);
        rd(ADDR_IRQ, 32'h2, 32'h2);
        send(8'h05);
        check(channel_output, 32'h05);
        check(link.fault_alarm_n, 32'h1);
        open_sense_low <= 8'h00;
        $display("open load test done");
        // overcurrent on channel three, latched until written zero
        overcurrent_sense <= 8'h04;
        repeat (OC_T - 8) @(posedge pclk);
        check(channel_output, 32'h05);
        repeat (20) @(posedge pclk);
        check(channel_output, 32'h01);
        check(link.fault_alarm_n, 32'h0);
        overcurrent_sense <= 8'h00;
        send(8'h05);
        check(channel_output, 32'h01);
        frame(32'h6);
        rd(ADDR_RDATA, 32'h0400, 32'hffff);
        send(8'h01);
        send(8'h05);
        check(channel_output, 32'h05);
        check(link.fault_alarm_n, 32'h1);
        $display("overcurrent test done");
        // over-temperature forces all off, then recovers
        over_temp <= 1'b1;
        repeat (10) @(posedge pclk);
        check(channel_output, 32'h0);
        over_temp <= 1'b0;
        repeat (10) @(posedge pclk);
        check(channel_output, 32'h05);
        $display("thermal test done");
        // enable dropped mid-run clears the channel bits
        wr(ADDR_CTRL, 32'h0);
        repeat (10) @(posedge pclk);
        check(channel_output, 32'h0);
        check(link.sdo_oe_n, 32'h1);
        wr(ADDR_CTRL, 32'h4);
        repeat (10) @(posedge pclk);
        check(channel_output, 32'h0);
        send(8'h81);
        check(channel_output, 32'h81);
        $display("enable test done");
        finish_test();
    end
endmodule : tb
